//--- src/tcl_phy_lane_cfg.sv
// tcl_phy_lane_cfg: display-side configuration of a two-lane USB-C PHY buffer
// assumes a classic Wishbone master on ref_clk_in and pin-level status from the
// connector microcontroller, which may change at any time
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "tcl_cfg.svh"
module tcl_phy_lane_cfg
  import tcl_pkg::*;
(
  input  wire logic                  ref_clk_in,      // 250 MHz register clock
  input  wire logic                  reset_n_in,      // synchronous reset, low
  input  wire logic                  wb_cyc_in,       // bus cycle
  input  wire logic                  wb_stb_in,       // bus strobe
  input  wire logic                  wb_we_in,        // write when high
  input  wire logic [13:0]           wb_adr_in,       // byte address
  input  wire logic [3:0]            wb_sel_in,       // byte enables
  input  wire logic [31:0]           wb_dat_in,       // write data
  output logic [31:0]                wb_dat_out,      // read data
  output logic                       wb_ack_out,      // acknowledge
  input  wire logic [3:0]            pin_assign_code_in,      // connector pin assignment
  input  wire logic [3:0]            wide_lane_assign_mask_in, // x4 lane mask
  input  wire logic [3:0]            live_state_in,   // live state per connector
  input  wire logic                  modular_adapter_flag_in, // two-connector adapters
  input  wire logic [1:0]            adapter_index_in, // adapter instance
  input  wire logic                  aux_ack_in,      // aux power acknowledge
  input  wire logic                  phy_micro_ok_in, // phy microcontroller health
  output logic [1:0]                 lane_pri_en_out, // primary tx enable per lane
  output logic [1:0]                 lane_sec_en_out, // secondary tx enable per lane
  output logic [1:0]                 lane_rx_en_out,  // secondary rx enable per lane
  output tcl_drive_type [1:0]        pri_drive_out,   // applied primary codes
  output tcl_drive_type [1:0]        sec_drive_out,   // applied secondary codes
  output logic [3:0]                 lane_count_out,  // main-link lanes in use
  output logic [1:0]                 port_width_out,  // port width selection
  output logic                       aux_req_out      // aux power request
);
  localparam int unsigned TO_CYC = `TCL_HEALTH_TO_CYC;

  typedef struct packed {
    logic [16:0]           s1;       // first sync stage, read by s2 only
    logic [16:0]           s2;       // synchronised pins
    logic                  ack;
    logic [31:0]           rdata;
    logic [1:0][2:0][31:0] drv;      // staged drive words per lane
    tcl_drive_type [1:0]   pri;      // applied primary codes
    tcl_drive_type [1:0]   sec;      // applied secondary codes
    tcl_sel_type [1:0]     sel;      // lane select pairs
    logic [3:0]            lane_en;
    logic [5:0]            buf_ctl;  // {conn[1:0], rsvd, width[1:0], en}
    logic                  aux_req;
    logic [11:0]           to_cnt;
    logic                  to_flag;  // sticky health timeout
  } tcl_state_type;

  tcl_state_type q_q;
  tcl_state_type d_d;

  // synchronised pin fields
  logic [3:0]  pa_s;
  logic [3:0]  mask_s;
  logic [3:0]  live_s;
  logic        mf_s;
  logic [1:0]  idx_s;
  logic        ack_s;
  logic        ok_s;
  assign {pa_s, mask_s, live_s, mf_s, idx_s, ack_s, ok_s} = q_q.s2;

  // bus request decode
  logic        req;
  logic        wr;
  logic        drv_hit;
  logic        lane_sel;
  logic [1:0]  drv_idx;
  logic [31:0] bmask;
  assign req      = wb_cyc_in & wb_stb_in;
  assign wr       = req & q_q.ack & wb_we_in;
  assign drv_hit  = (wb_adr_in[13:5] == 9'h000) && (wb_adr_in[3:2] != 2'h3);
  assign lane_sel = wb_adr_in[4];
  assign drv_idx  = wb_adr_in[3:2];
  assign bmask    = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

  // port activity: only a live connector may drive lanes
  logic        port_on;
  logic [1:0]  lane_on;
  assign port_on    = q_q.buf_ctl[0] & live_s[q_q.buf_ctl[5:4]];
  assign lane_on[0] = port_on & (|q_q.lane_en[1:0]);
  assign lane_on[1] = port_on & (|q_q.lane_en[3:2]);

  // connector-to-port mapping, readable by software
  tcl_port_type [3:0] port_num;
  tcl_port_map u_map (
    .modular_in   (mf_s),
    .adapter_in   (idx_s),
    .port_num_out (port_num)
  );

  // one decoder per PHY lane, each lane with its two transmitters
  genvar l;
  generate
    for (l = 0; l < 2; l++) begin : g_lane
      tcl_lane_decode u_dec (
        .sel_in     (q_q.sel[l]),
        .lane_on_in (lane_on[l]),
        .pri_en_out (lane_pri_en_out[l]),
        .sec_en_out (lane_sec_en_out[l]),
        .rx_en_out  (lane_rx_en_out[l])
      );
    end
  endgenerate

  // status word: live bits of connectors 2 and 3 read zero with modular adapters
  logic [31:0] stat_word;
  logic [3:0]  live_vis;
  assign live_vis  = live_s & {~mf_s, ~mf_s, 2'b11};
  assign stat_word = {20'h00000, live_vis, 3'h0, mf_s, mask_s};

  // read mux, unmapped addresses answer zero
  logic [31:0] rd;
  always_comb begin
    rd = `TCL_RESET_WORD;
    if (drv_hit) begin
      rd = q_q.drv[lane_sel][drv_idx];
    end else begin
      case (wb_adr_in)
        `TCL_OFS_SEL0:   rd = {30'h0, q_q.sel[0]};
        `TCL_OFS_SEL1:   rd = {30'h0, q_q.sel[1]};
        `TCL_OFS_PA:     rd = {28'h0, pa_s};
        `TCL_OFS_STAT:   rd = stat_word;
        `TCL_OFS_LEN:    rd = {28'h0, q_q.lane_en};
        `TCL_OFS_BUF:    rd = {26'h0, q_q.buf_ctl};
        `TCL_OFS_AUX:    rd = {28'h0, q_q.to_flag, ok_s, ack_s, q_q.aux_req};
        `TCL_OFS_MAP:    rd = {16'h0, 1'b0, port_num[3], 1'b0, port_num[2],
                               1'b0, port_num[1], 1'b0, port_num[0]};
        `TCL_OFS_HEALTH: rd = {16'h0, ok_s, 15'h0000};
        default:         rd = `TCL_RESET_WORD;
      endcase
    end
  end

  // next state: sync, bus answer, writes, drive apply and health watchdog
  logic [31:0] wv;
  logic [31:0] cur;
  logic        to_set;
  always_comb begin
    d_d    = q_q;
    cur    = rd;
    wv     = (cur & ~bmask) | (wb_dat_in & bmask);
    to_set = 1'b0;
    d_d.s1 = {pin_assign_code_in, wide_lane_assign_mask_in, live_state_in,
              modular_adapter_flag_in, adapter_index_in, aux_ack_in, phy_micro_ok_in};
    d_d.s2 = q_q.s1;
    // one wait state, then ack for a single cycle
    d_d.ack = req & ~q_q.ack;
    if (req & ~q_q.ack) begin
      d_d.rdata = rd;
    end
    // health wait: count while ack is up and health is still low
    if (q_q.aux_req & ack_s & ~ok_s) begin
      if (q_q.to_cnt >= 12'(TO_CYC - 1)) begin
        to_set = 1'b1;
      end else begin
        d_d.to_cnt = q_q.to_cnt + 12'h001;
      end
    end else begin
      d_d.to_cnt = 12'h000;
    end
    // writes take effect on the edge that the master samples ack
    if (wr) begin
      if (drv_hit) begin
        if (drv_idx == 2'h2) begin
          d_d.drv[lane_sel][2] = wv & `TCL_COM_MASK;
          // wide word set: staged codes become live on this lane
          if (wv[`TCL_WIDE_BIT]) begin
            d_d.pri[lane_sel] = {q_q.drv[lane_sel][0][17:13],
                                 q_q.drv[lane_sel][0][12:8],
                                 q_q.drv[lane_sel][0][2:0]};
            d_d.sec[lane_sel] = {q_q.drv[lane_sel][1][17:13],
                                 q_q.drv[lane_sel][1][12:8],
                                 q_q.drv[lane_sel][1][2:0]};
          end
        end else begin
          d_d.drv[lane_sel][drv_idx] = wv & `TCL_DRV_MASK;
        end
      end else begin
        case (wb_adr_in)
          `TCL_OFS_SEL0: d_d.sel[0]   = wv[1:0];
          `TCL_OFS_SEL1: d_d.sel[1]   = wv[1:0];
          `TCL_OFS_LEN:  d_d.lane_en  = wv[3:0];
          `TCL_OFS_BUF:  d_d.buf_ctl  = wv[5:0] & `TCL_BUF_MASK;
          `TCL_OFS_AUX: begin
            d_d.aux_req = wv[0];
            if (wv[3]) begin
              d_d.to_flag = 1'b0;
            end
          end
          default: ;
        endcase
      end
    end
    // a timeout in the clearing cycle is kept
    if (to_set) begin
      d_d.to_flag = 1'b1;
    end
  end

  // single state register, synchronous reset to all zero
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      q_q <= '0;
    end else begin
      q_q <= d_d;
    end
  end

  // outputs straight from flops
  assign wb_ack_out     = q_q.ack;
  assign wb_dat_out     = q_q.rdata;
  assign pri_drive_out  = q_q.pri;
  assign sec_drive_out  = q_q.sec;
  assign lane_count_out = q_q.lane_en;
  assign port_width_out = q_q.buf_ctl[2:1];
  assign aux_req_out    = q_q.aux_req;

  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  ack_single_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than one cycle");
  ack_after_request_a: assert property (req && !wb_ack_out |=> wb_ack_out)
    else $error("request not answered next cycle");
  rx_stays_off_a: assert property (lane_rx_en_out == 2'b00)
    else $error("secondary receiver enabled");
  dual_enables_both_a: assert property (q_q.sel[0][1] && lane_on[0] |-> lane_pri_en_out[0] && lane_sec_en_out[0])
    else $error("dual select did not enable both");
  secondary_only_a: assert property (q_q.sel[1] == 2'b01 && lane_on[1] |-> !lane_pri_en_out[1] && lane_sec_en_out[1])
    else $error("secondary-only decode wrong");
  unused_lane_off_a: assert property (q_q.lane_en[3:2] == 2'b00 |-> lane_pri_en_out[1] == 1'b0 && !lane_sec_en_out[1])
    else $error("unused lane still enabled");
  disconnected_port_off_a: assert property (!live_s[q_q.buf_ctl[5:4]] |-> lane_pri_en_out == 2'b00 && lane_sec_en_out == 2'b00)
    else $error("lanes driven on disconnected port");
  mono_port_map_a: assert property (!mf_s |-> port_num[3] == 3'h4 && port_num[0] == 3'h1)
    else $error("monolithic mapping wrong");
  modular_reserved_a: assert property (mf_s |-> port_num[2] == 3'h0 && port_num[3] == 3'h0)
    else $error("reserved connector mapped");
  modular_status_a: assert property (req && !wb_ack_out && wb_adr_in == `TCL_OFS_STAT && !wb_we_in
    |=> wb_dat_out[`TCL_MF_BIT] == $past(mf_s))
    else $error("modular flag misreported");
  apply_on_wide_a: assert property (wr && drv_hit && drv_idx == 2'h2 && !lane_sel && wv[`TCL_WIDE_BIT]
    |=> pri_drive_out[0][2:0] == $past(q_q.drv[0][0][2:0]))
    else $error("drive codes not applied");

  cov_wide_write_c:  cover property (wr && drv_hit && drv_idx == 2'h2 && wv[`TCL_WIDE_BIT]);
  cov_dual_lane_c:   cover property (lane_pri_en_out[0] && lane_sec_en_out[0]);
  cov_timeout_c:     cover property (to_set);
  cov_modular_map_c: cover property (mf_s && port_num[1] == 3'h4);
endmodule
`default_nettype wire

//--- src/tcl_cfg.svh
// tcl_cfg.svh: offsets, field positions, reset values and timing for the lane mode block
// assumes a 32-bit word-addressed register map with byte addresses on a 14-bit bus
`ifndef TCL_CFG_SVH
`define TCL_CFG_SVH
`define TCL_ADR_W        14
`define TCL_OFS_SEL0     14'h0020
`define TCL_OFS_SEL1     14'h0024
`define TCL_OFS_PA       14'h0030
`define TCL_OFS_STAT     14'h0034
`define TCL_OFS_LEN      14'h0038
`define TCL_OFS_BUF      14'h003c
`define TCL_OFS_AUX      14'h0040
`define TCL_OFS_MAP      14'h0044
`define TCL_OFS_HEALTH   14'h236c
`define TCL_DRV_MASK     32'h0003ff07
`define TCL_COM_MASK     32'h00000004
`define TCL_WIDE_BIT     2
`define TCL_MF_BIT       4
`define TCL_LIVE_LSB     8
`define TCL_HEALTH_BIT   15
`define TCL_BUF_MASK     6'h37
`define TCL_RESET_WORD   32'h00000000
`define TCL_HEALTH_TO_NS 10000
`define TCL_CLK_NS       4
`define TCL_HEALTH_TO_CYC (`TCL_HEALTH_TO_NS / `TCL_CLK_NS)
`endif

//--- src/tcl_pkg.sv
// tcl_pkg: shared types of the lane mode block
// assumes tcl_cfg.svh is on the include path
package tcl_pkg;
  // per-transmitter applied drive word {pre[4:0], post[4:0], swing[2:0]}
  typedef logic [12:0] tcl_drive_type;
  // lane select pair {dual, secondary only}
  typedef logic [1:0]  tcl_sel_type;
  // port number 1..6, zero marks a reserved connector field
  typedef logic [2:0]  tcl_port_type;
endpackage

//--- src/tcl_lane_decode.sv
// tcl_lane_decode: turns one lane's select pair into transmitter enables
// assumes select and lane power come from flops on the same clock
`timescale 1ns/10ps
`default_nettype none
module tcl_lane_decode
  import tcl_pkg::*;
(
  input  wire tcl_sel_type sel_in,     // {dual, secondary only}
  input  wire logic        lane_on_in, // lane in use by an active port
  output logic             pri_en_out, // primary transmitter enable
  output logic             sec_en_out, // secondary transmitter enable
  output logic             rx_en_out   // secondary receive enable
);
  // dual wins over secondary-only; an unused lane is shut down whatever its fields say
  always_comb begin
    pri_en_out = lane_on_in & (sel_in[1] | ~sel_in[0]);
    sec_en_out = lane_on_in & (sel_in[1] | sel_in[0]);
    rx_en_out  = 1'b0;
  end
endmodule
`default_nettype wire

//--- src/tcl_port_map.sv
// tcl_port_map: maps the adapter's connector fields to system port numbers
// assumes the modular flag and adapter index are already synchronised
`timescale 1ns/10ps
`default_nettype none
module tcl_port_map
  import tcl_pkg::*;
(
  input  wire logic               modular_in,  // two-connector adapters in use
  input  wire logic [1:0]         adapter_in,  // adapter instance, 0 based
  output tcl_port_type [3:0]      port_num_out // port per connector, 0 = reserved
);
  genvar c;
  // one entry per connector field
  generate
    for (c = 0; c < 4; c++) begin : g_conn
      always_comb begin
        if (!modular_in) begin
          port_num_out[c] = 3'(c + 1);
        end else if (c > 1 || adapter_in == 2'h3) begin
          port_num_out[c] = 3'h0;
        end else begin
          port_num_out[c] = 3'({adapter_in, 1'b0}) + 3'(c + 1);
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

//--- testbench/tcl_uc_model.sv
// tcl_uc_model: connector microcontroller and phy health source for the bench
// assumes the bench sets the arrangement on the cfg inputs just after a clock edge
`timescale 1ns/10ps
`default_nettype none
module tcl_uc_model (
  input  wire logic       ref_clk_in,  // register clock
  input  wire logic [3:0] pa_cfg_in,   // assignment to publish, 1..6 or 0
  input  wire logic [3:0] mask_cfg_in, // x4 lane mask to publish
  input  wire logic [3:0] live_cfg_in, // live connectors
  input  wire logic [2:0] adp_cfg_in,  // {modular, adapter index}
  input  wire logic [3:0] ack_dly_in,  // aux ack delay in cycles
  input  wire logic       sick_in,     // withhold the health bit
  input  wire logic       aux_req_in,  // aux power request
  output logic [3:0]      pa_out,      // published pin assignment
  output logic [3:0]      mask_out,    // published lane mask
  output logic [3:0]      live_out,    // live state per connector
  output logic [2:0]      adp_out,     // {modular, adapter index}
  output logic            aux_ack_out, // aux power acknowledge
  output logic            ok_out       // phy microcontroller health
);
  logic [4:0] cnt_q;
  // whole arrangement moves in one edge so the pins never show a mix
  // ack and health drop with the request: nothing holds power unasked
  always @(posedge ref_clk_in) begin
    {pa_out, mask_out, live_out, adp_out} <= {pa_cfg_in, mask_cfg_in, live_cfg_in, adp_cfg_in};
    cnt_q <= !aux_req_in ? 5'h00 : (cnt_q == 5'h1f) ? cnt_q : cnt_q + 5'h01;
    aux_ack_out <= aux_req_in && (cnt_q >= {1'b0, ack_dly_in});
    ok_out <= aux_req_in && !sick_in && (cnt_q >= {1'b0, ack_dly_in} + 5'h04);
  end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// testbench: register, lane decode, port map and aux power checks of the lane block
// assumes the connector model on the pin side and the offsets of tcl_cfg.svh
`timescale 1ns/10ps
`default_nettype none
`include "tcl_cfg.svh"
module testbench;
  import tcl_pkg::*;
  logic                 ref_clk = 1'b0;
  logic                 reset_n = 1'b0;
  logic                 cyc = 1'b0, stb = 1'b0, we = 1'b0, sick = 1'b0;
  logic [13:0]          adr = 14'h0000;
  logic [31:0]          wdat = 32'h0, rdat, rbuf, d0, d1, r;
  int                   seed;
  logic [3:0]           e;
  logic [3:0]           pa_cfg = 4'h1, mask_cfg = 4'hf, live_cfg = 4'h0, ack_dly = 4'h3;
  logic [2:0]           adp_cfg = 3'h0;
  logic [3:0]           pa, mask, live, lane_cnt;
  logic [2:0]           adp;
  logic [1:0]           pri_en, sec_en, rx_en, width;
  logic                 ack, aux_ack, ok, aux_req;
  tcl_drive_type [1:0]  pri_drv, sec_drv;
  logic [13:0]          base;
  int                   bad_count = 0, samples_checked = 0;

  always #2 ref_clk = ~ref_clk;

  tcl_phy_lane_cfg u_tcl_phy_lane_cfg (.ref_clk_in(ref_clk), .reset_n_in(reset_n), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .pin_assign_code_in(pa), .wide_lane_assign_mask_in(mask),
    .live_state_in(live), .modular_adapter_flag_in(adp[2]), .adapter_index_in(adp[1:0]),
    .aux_ack_in(aux_ack), .phy_micro_ok_in(ok), .lane_pri_en_out(pri_en), .lane_sec_en_out(sec_en),
    .lane_rx_en_out(rx_en), .pri_drive_out(pri_drv), .sec_drive_out(sec_drv),
    .lane_count_out(lane_cnt), .port_width_out(width), .aux_req_out(aux_req));

  tcl_uc_model u_tcl_uc_model (.ref_clk_in(ref_clk), .pa_cfg_in(pa_cfg), .mask_cfg_in(mask_cfg),
    .live_cfg_in(live_cfg), .adp_cfg_in(adp_cfg), .ack_dly_in(ack_dly), .sick_in(sick),
    .aux_req_in(aux_req), .pa_out(pa), .mask_out(mask), .live_out(live), .adp_out(adp),
    .aux_ack_out(aux_ack), .ok_out(ok));

  task automatic report_and_stop;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one classic cycle; request held until ack is sampled, then released
  task automatic wb(input logic w, input logic [13:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    rbuf = rdat;
    {cyc, stb} <= 2'b00;
    if (ack !== 1'b1) begin
      bad_count++;
      report_and_stop();
    end
  endtask

  task automatic rd(input logic [13:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(rbuf, exp);
  endtask

  // applied drive word {pre, post, swing} from a register image
  function automatic logic [31:0] dw(input logic [31:0] d);
    return {19'h0, d[17:13], d[12:8], d[2:0]};
  endfunction

  // expected port per connector nibble, zero where the field is reserved
  function automatic logic [31:0] map_exp(input logic [2:0] a);
    logic [31:0] m;
    m = 32'h0;
    for (int c = 0; c < 4; c++) begin
      if (!a[2]) m[4*c +: 3] = 3'(c + 1);
      else if (c < 2 && a[1:0] != 2'd3) m[4*c +: 3] = 3'(2 * a[1:0] + c + 1);
    end
    return m;
  endfunction

  // software select derivation {lane1, lane0}; width 0 = x1, 1 = x2, 2 = x4
  function automatic logic [3:0] sel_exp(input logic [3:0] p, input logic [3:0] m, input logic [1:0] w);
    if (p == 4'h1 && m == 4'hf && w == 2'h2) return 4'b1010;
    if (p == 4'h2 && (m == 4'hc || m == 4'h3) && w == 2'h1) return 4'b1010;
    if ((p == 4'h3 || p == 4'h5) && m == 4'hf) return (w == 2'h0) ? 4'b0101 : 4'b1010;
    if ((p == 4'h4 || p == 4'h6) && (m == 4'hc || m == 4'h3)) return (w == 2'h0) ? 4'b0101 : 4'b1010;
    if (p == 4'h0) return (w == 2'h0) ? 4'b0100 : 4'b1010;
    return 4'b0000; // unmapped: selects 00, primary transmitter only on both lanes
  endfunction

  initial begin
    seed = 32'he0ae9046;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    // reset images: codes all zero, selects zero
    rd(14'h0000, 32'h0);
    rd(14'h0014, 32'h0);
    rd(14'h0024, 32'h0);
    // staged codes apply only when the wide word bit is written
    for (int l = 0; l < 2; l++) begin
      base = l ? 14'h0010 : 14'h0000;
      d0 = $random(seed);
      d1 = $random(seed);
      wb(1'b1, base, d0);
      wb(1'b1, base + 14'h0004, d1);
      rd(base, d0 & `TCL_DRV_MASK);
      rd(base + 14'h0004, d1 & `TCL_DRV_MASK);
      check({19'h0, pri_drv[l]}, 32'h0);
      wb(1'b1, base + 14'h0008, 32'hffff_ffff);
      @(posedge ref_clk);
      @(negedge ref_clk);
      check({19'h0, pri_drv[l]}, dw(d0));
      check({19'h0, sec_drv[l]}, dw(d1));
      rd(base + 14'h0008, `TCL_COM_MASK);
    end
    // table corner: level 0 with maximum emphasis, swing 0 and post-cursor 17
    wb(1'b1, 14'h0000, 32'h0000_1700);
    wb(1'b1, 14'h0008, 32'h0000_0004);
    @(negedge ref_clk);
    check({19'h0, pri_drv[0]}, {19'h0, 5'h00, 5'h17, 3'h0});
    // lane decode with connector 1 live and both lanes enabled
    live_cfg <= 4'hf;
    r = $random(seed);
    wb(1'b1, 14'h003c, {26'h0, 2'b01, 1'b0, r[1:0], 1'b1});
    wb(1'b1, 14'h0038, 32'hf);
    rd(14'h003c, {26'h0, 2'b01, 1'b0, r[1:0], 1'b1});
    check({30'h0, width}, {30'h0, r[1:0]});
    check({28'h0, lane_cnt}, 32'hf);
    for (int s = 0; s < 4; s++) begin
      wb(1'b1, 14'h0020, 32'(s));
      wb(1'b1, 14'h0024, 32'(3 - s));
      @(negedge ref_clk);
      check({30'h0, pri_en}, {30'h0, s < 2 || s == 3, s != 1});
      check({30'h0, sec_en}, {30'h0, s != 3, s != 0});
      check({30'h0, rx_en}, 32'h0);
    end
    wb(1'b1, 14'h0038, 32'h3);
    @(negedge ref_clk);
    check({28'h0, pri_en, sec_en}, 32'h5);
    live_cfg <= 4'hd;
    repeat (6) @(posedge ref_clk);
    check({28'h0, pri_en, sec_en}, 32'h0);
    // status and port map across all six assignments, reserved index first
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      pa_cfg <= 4'(i + 1);
      mask_cfg <= r[7:4];
      live_cfg <= r[11:8];
      adp_cfg <= (i == 0) ? 3'b111 : r[14:12];
      repeat (6) @(posedge ref_clk);
      rd(14'h0030, 32'(i + 1));
      rd(14'h0034, {20'h0, r[11:8] & (adp_cfg[2] ? 4'h3 : 4'hf), 3'h0, adp_cfg[2], r[7:4]});
      rd(14'h0044, map_exp(adp_cfg));
      e = sel_exp(4'(i + 1), r[7:4], r[17:16]);
      wb(1'b1, 14'h0020, {30'h0, e[1:0]});
      wb(1'b1, 14'h0024, {30'h0, e[3:2]});
      rd(14'h0020, {30'h0, e[1:0]});
      rd(14'h0024, {30'h0, e[3:2]});
    end
    wb(1'b1, 14'h0030, 32'hffff_ffff);
    rd(14'h0030, 32'h6);
    rd(14'h0100, 32'h0);
    // health never comes: no flag before the limit, flag after it
    sick <= 1'b1;
    ack_dly <= 4'h8;
    wb(1'b1, 14'h0040, 32'h1);
    repeat (2440) @(posedge ref_clk);
    rd(14'h0040, 32'h3);
    repeat (100) @(posedge ref_clk);
    rd(14'h0040, 32'hb);
    sick <= 1'b0;
    repeat (10) @(posedge ref_clk);
    wb(1'b1, 14'h0040, 32'h9);
    repeat (4) @(posedge ref_clk);
    rd(14'h0040, 32'h7);
    rd(14'h236c, 32'h8000);
    wb(1'b1, 14'h0040, 32'h0);
    repeat (8) @(posedge ref_clk);
    rd(14'h0040, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
